// file: hdl/adc_config_scan_control_defs.vh
`ifndef ADC_CONFIG_SCAN_CONTROL_DEFS_VH
`define ADC_CONFIG_SCAN_CONTROL_DEFS_VH

// power-up values
`define CFG_RESET_VAL      8'h01
`define SETUP_RESET_VAL    8'h82

// conversion_configuration fields
`define CFG_SCAN_HI        6
`define CFG_SCAN_LO        5
`define CFG_CS3            4
`define CFG_CS2            3
`define CFG_CS1            2
`define CFG_CS0            1
`define CFG_INPUT_PAIRING_SEL         0

// setup byte fields
`define SET_TYPE_BIT       7
`define SET_VREF_SOURCE_HI           6
`define SET_VREF_SOURCE_LO           5
`define SET_REF_PWR        4
`define SET_EXT_CLK        3
`define SET_POLARITY       2
`define SET_RESET_N        1
`define SET_MON_SETUP      0

// scan field codes
`define SCAN_RANGE         2'h0
`define SCAN_REPEAT        2'h1
`define SCAN_MONITOR       2'h2
`define SCAN_SINGLE        2'h3

// bus constants
`define MON_SETUP_BYTES    13
`define REPEAT_COUNT       8
`define HS_CODE_TOP        5'h01
`define SLAVE_ADDR_DEFAULT 7'h34

`endif

// file: hdl/adc_config_scan_control.v
`timescale 1ns/10ps
`default_nettype none
`include "adc_config_scan_control_defs.vh"

// Function
// R01: after the address, msb 1 means setup byte, msb 0 configuration byte
// R02: scan 00 converts channel 0 up to the selected channel
// R03: scan 01 converts the selected channel eight times, eight results
// R04: scan 10 runs a continuous repeating scan from channel 0 upward
// R05: scan 11 performs exactly one conversion on the selected channel
// R06: low channel bits are upper limit or single channel depending on scan
// R07: both upper channel bits set enables readback of monitor setup data
// R08: bit 0 selects single-ended or differential, pairs 0/1 and 2/3
// R09: single-ended forces unipolar conversions, polarity bit ignored
// R10: shared input used as reference is left out of multichannel scans
// R11: results kept in conversion order; a read starts the scan, returns them
// R12: write cycle: start, seven address bits, write bit; address is acked
// R13: master writes configuration before setup, again after a reset
// R14: setup reset returns configuration register to its power-up value
// R15: monitor setup bit accepts up to thirteen further setup data bytes
// R16: stop or repeated start ends monitor setup data acceptance
// R17: every received write data byte is acknowledged
// R18: stop returns high-speed bus timing to standard/fast mode
// R19: external clock idles on stop/nack/sr; internal after results stored
// R20: idle device watches for its address and powers up on it
// R21: master should wake the internal reference ten ms before converting
// R22: setup bit 1 at 0 clears interrupt and configuration, not setup
// R23: outside monitor setup each data byte is decoded by its top bit
module adc_config_scan_control #(
   parameter [6:0] SLAVE_ADDR = `SLAVE_ADDR_DEFAULT,
   parameter       MON_BYTES  = `MON_SETUP_BYTES,
   parameter       RES_DEPTH  = `REPEAT_COUNT
) (
   input  wire        ref_clk,
   input  wire        rst,
   input  wire        scl_in,
   output wire        scl_out,
   output reg         scl_oe,
   input  wire        sda_in,
   output wire        sda_out,
   output reg         sda_oe,
   input  wire        a0_pin,
   output reg         conv_start,
   output reg  [1:0]  conv_chan,
   output wire [1:0]  conv_neg_chan,
   output wire        conv_diff,
   output wire        conv_bipolar,
   input  wire        conv_done,
   input  wire [11:0] conv_data,
   output wire [1:0]  vref_sel,
   output wire        ref_power_on,
   output wire        ext_clock_sel,
   output reg         hs_mode,
   output reg         powered,
   output wire        monitor_active,
   output wire        readback_en,
   output reg         int_clear
);

   localparam [2:0] ST_IDLE = 3'd0;
   localparam [2:0] ST_ADDR = 3'd1;
   localparam [2:0] ST_WR   = 3'd2;
   localparam [2:0] ST_RD   = 3'd3;
   localparam [2:0] ST_CONV = 3'd4;

   reg  [1:0]  scl_sy_q;
   reg  [1:0]  sda_sy_q;
   reg  [1:0]  a0_sy_q;
   reg         scl_p_q;
   reg         sda_p_q;
   reg  [2:0]  state_q;
   reg  [3:0]  cnt_q;
   reg  [7:0]  sh_q;
   reg  [7:0]  tx_q;
   reg         mack_q;
   reg  [7:0]  cfg_q;
   reg  [7:0]  setup_q;
   reg  [3:0]  mon_idx_q;
   reg         mon_on_q;
   reg  [3:0]  ptr_q;
   reg         half_q;
   reg         scan_go_q;
   reg  [7:0]  mon_mem [0:MON_BYTES-1];
   reg  [13:0] res_mem [0:RES_DEPTH-1];
   reg         sc_busy_q;
   reg  [2:0]  sc_idx_q;
   reg  [3:0]  sc_len_q;
   reg  [3:0]  res_len_q;
   reg         scan_end_q;

   wire        scl_s;
   wire        sda_s;
   wire        scl_rise;
   wire        scl_fall;
   wire        start_c;
   wire        stop_c;
   wire [6:0]  my_addr;
   wire        sequence_sel_hi;
   wire        sequence_sel_lo;
   wire        chan_pick_b3;
   wire        chan_pick_b2;
   wire [1:0]  chan_lim;
   wire        input_pairing_sel;
   wire        polarity_sel;
   wire        vref_source_hi;
   wire        vref_source_lo;
   wire [1:0]  scan_mode;
   wire        multi;
   wire        keep_pwr;
   reg  [3:0]  len_c;
   reg  [3:0]  nxt_ptr;
   reg         nxt_half;
   reg         wrap_c;
   reg  [7:0]  first_byte;
   reg  [7:0]  next_byte;
   reg  [13:0] rw_c;

   // pin synchronisers
   always @(posedge ref_clk) begin
      if (rst) begin
         scl_sy_q <= 2'h3;
         sda_sy_q <= 2'h3;
         a0_sy_q  <= 2'h0;
         scl_p_q  <= 1'b1;
         sda_p_q  <= 1'b1;
      end else begin
         scl_sy_q <= {scl_sy_q[0], scl_in};
         sda_sy_q <= {sda_sy_q[0], sda_in};
         a0_sy_q  <= {a0_sy_q[0], a0_pin};
         scl_p_q  <= scl_sy_q[1];
         sda_p_q  <= sda_sy_q[1];
      end
   end

   assign scl_s    = scl_sy_q[1];
   assign sda_s    = sda_sy_q[1];
   assign scl_rise = scl_s & ~scl_p_q;
   assign scl_fall = ~scl_s & scl_p_q;
   assign start_c  = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign stop_c   = scl_s & scl_p_q & ~sda_p_q & sda_s;
   assign my_addr  = {SLAVE_ADDR[6:1], a0_sy_q[1]};

   assign scl_out  = 1'b0;
   assign sda_out  = 1'b0;

   // field decode
   assign sequence_sel_hi   = cfg_q[`CFG_SCAN_HI];
   assign sequence_sel_lo   = cfg_q[`CFG_SCAN_LO];
   assign chan_pick_b3      = cfg_q[`CFG_CS3];
   assign chan_pick_b2      = cfg_q[`CFG_CS2];
   assign chan_lim          = {cfg_q[`CFG_CS1], cfg_q[`CFG_CS0]};
   assign input_pairing_sel = cfg_q[`CFG_INPUT_PAIRING_SEL];
   assign polarity_sel      = setup_q[`SET_POLARITY];
   assign vref_source_hi    = setup_q[`SET_VREF_SOURCE_HI];
   assign vref_source_lo    = setup_q[`SET_VREF_SOURCE_LO];
   assign scan_mode         = {sequence_sel_hi, sequence_sel_lo};
   assign multi             = ~sequence_sel_lo; // R06

   assign vref_sel       = {vref_source_hi, vref_source_lo};
   assign ref_power_on   = setup_q[`SET_REF_PWR];
   assign ext_clock_sel  = setup_q[`SET_EXT_CLK];
   assign monitor_active = (scan_mode == `SCAN_MONITOR);
   assign readback_en    = chan_pick_b3 & chan_pick_b2; // R07
   assign conv_diff      = ~input_pairing_sel; // R08
   assign conv_neg_chan  = conv_chan ^ 2'h1; // R08
   assign conv_bipolar   = polarity_sel & ~input_pairing_sel; // R09
   assign keep_pwr       = monitor_active | sc_busy_q;

   // scan length per mode
   always @* begin
      case (scan_mode)
         `SCAN_REPEAT: len_c = 4'd8; // R03
         `SCAN_SINGLE: len_c = 4'd1; // R05
         default: begin
            len_c = {2'b00, chan_lim} + 4'd1; // R02 R04
            if (vref_source_lo && chan_lim == 2'h3) begin
               len_c = 4'd3; // R10
            end
         end
      endcase
   end

   // read pointer advance and byte assembly
   always @* begin
      nxt_ptr  = ptr_q;
      nxt_half = half_q;
      wrap_c   = 1'b0;
      rw_c     = res_mem[0];
      if (readback_en) begin
         wrap_c  = (ptr_q == MON_BYTES - 1);
         nxt_ptr = wrap_c ? 4'd0 : ptr_q + 4'd1;
      end else begin
         nxt_half = ~half_q;
         if (half_q) begin
            wrap_c  = (ptr_q + 4'd1 >= res_len_q); // R11
            nxt_ptr = wrap_c ? 4'd0 : ptr_q + 4'd1;
         end
      end
      first_byte = readback_en ? mon_mem[0] :
                   {1'b1, res_mem[0][13:12], 1'b1, res_mem[0][11:8]};
      if (readback_en) begin
         next_byte = mon_mem[nxt_ptr];
      end else begin
         rw_c      = res_mem[nxt_ptr[2:0]];
         next_byte = nxt_half ? rw_c[7:0] :
                     {1'b1, rw_c[13:12], 1'b1, rw_c[11:8]};
      end
   end

   // bus engine and byte decode
   always @(posedge ref_clk) begin
      if (rst) begin
         state_q   <= ST_IDLE;
         cnt_q     <= 4'd0;
         sh_q      <= 8'h00;
         tx_q      <= 8'h00;
         mack_q    <= 1'b1;
         sda_oe    <= 1'b0;
         scl_oe    <= 1'b0;
         cfg_q     <= `CFG_RESET_VAL;
         setup_q   <= `SETUP_RESET_VAL;
         mon_idx_q <= 4'd0;
         mon_on_q  <= 1'b0;
         ptr_q     <= 4'd0;
         half_q    <= 1'b0;
         scan_go_q <= 1'b0;
         hs_mode   <= 1'b0;
         powered   <= 1'b0;
         int_clear <= 1'b0;
      end else begin
         int_clear <= 1'b0;
         scan_go_q <= 1'b0;
         scl_oe    <= (state_q == ST_CONV);
         if (scan_end_q && !ext_clock_sel && !monitor_active) begin
            powered <= 1'b0; // R19
         end
         if (start_c) begin
            state_q  <= ST_ADDR;
            cnt_q    <= 4'd0;
            sda_oe   <= 1'b0;
            mon_on_q <= 1'b0; // R16
            if (state_q != ST_IDLE && !keep_pwr) begin
               powered <= 1'b0; // R19
            end
         end else if (stop_c) begin
            state_q  <= ST_IDLE;
            sda_oe   <= 1'b0;
            hs_mode  <= 1'b0; // R18
            mon_on_q <= 1'b0; // R16
            if (!keep_pwr) begin
               powered <= 1'b0; // R19
            end
         end else if (state_q == ST_CONV) begin
            if (!sc_busy_q && !scan_go_q) begin
               tx_q    <= first_byte; // R11
               sda_oe  <= ~first_byte[7];
               ptr_q   <= 4'd0;
               half_q  <= 1'b0;
               state_q <= ST_RD;
            end
         end else if (state_q != ST_IDLE) begin
            if (scl_rise) begin
               if (cnt_q < 4'd8) begin
                  sh_q <= {sh_q[6:0], sda_s};
               end else begin
                  mack_q <= sda_s;
               end
               cnt_q <= cnt_q + 4'd1;
            end else if (scl_fall) begin
               if (cnt_q == 4'd8) begin
                  if (state_q == ST_RD) begin
                     sda_oe <= 1'b0;
                  end else if (state_q == ST_ADDR) begin
                     if (sh_q[7:1] == my_addr) begin
                        sda_oe  <= 1'b1; // R12
                        powered <= 1'b1; // R20
                     end else if (sh_q[7:3] == `HS_CODE_TOP) begin
                        hs_mode <= 1'b1;
                        state_q <= ST_IDLE;
                     end else begin
                        state_q <= ST_IDLE; // R20
                     end
                  end else begin
                     sda_oe <= 1'b1; // R17
                     if (mon_on_q) begin
                        mon_mem[mon_idx_q] <= sh_q; // R15
                        mon_idx_q <= mon_idx_q + 4'd1;
                        if (mon_idx_q == MON_BYTES - 1) begin
                           mon_on_q <= 1'b0; // R23
                        end
                     end else if (sh_q[7]) begin
                        setup_q <= sh_q; // R01 R23
                        if (!sh_q[`SET_RESET_N]) begin
                           cfg_q     <= `CFG_RESET_VAL; // R14 R22
                           int_clear <= 1'b1; // R22
                        end
                        if (sh_q[`SET_MON_SETUP]) begin
                           mon_on_q  <= 1'b1; // R15
                           mon_idx_q <= 4'd0;
                        end
                     end else begin
                        cfg_q <= sh_q; // R01
                     end
                  end
               end else if (cnt_q == 4'd9) begin
                  cnt_q  <= 4'd0;
                  sda_oe <= 1'b0;
                  if (state_q == ST_ADDR) begin
                     if (!sh_q[0]) begin
                        state_q <= ST_WR; // R12
                     end else if (readback_en) begin
                        tx_q    <= first_byte; // R07
                        sda_oe  <= ~first_byte[7];
                        ptr_q   <= 4'd0;
                        half_q  <= 1'b0;
                        state_q <= ST_RD;
                     end else begin
                        scan_go_q <= 1'b1; // R11
                        state_q   <= ST_CONV;
                     end
                  end else if (state_q == ST_RD) begin
                     if (mack_q) begin
                        state_q <= ST_IDLE;
                        if (!keep_pwr) begin
                           powered <= 1'b0; // R19
                        end
                     end else if (wrap_c && ext_clock_sel &&
                                  !readback_en && !monitor_active) begin
                        scan_go_q <= 1'b1;
                        state_q   <= ST_CONV;
                     end else begin
                        ptr_q  <= nxt_ptr;
                        half_q <= nxt_half;
                        tx_q   <= next_byte;
                        sda_oe <= ~next_byte[7];
                     end
                  end
               end else if (state_q == ST_RD) begin
                  sda_oe <= ~tx_q[3'd7 - cnt_q[2:0]];
               end
            end
         end
      end
   end

   // conversion sequencer
   always @(posedge ref_clk) begin
      if (rst) begin
         sc_busy_q  <= 1'b0;
         sc_idx_q   <= 3'd0;
         sc_len_q   <= 4'd1;
         res_len_q  <= 4'd1;
         scan_end_q <= 1'b0;
         conv_start <= 1'b0;
         conv_chan  <= 2'h0;
      end else begin
         conv_start <= 1'b0;
         scan_end_q <= 1'b0;
         if (!sc_busy_q) begin
            if (scan_go_q || (monitor_active && powered)) begin // R04
               sc_busy_q  <= 1'b1;
               sc_idx_q   <= 3'd0;
               sc_len_q   <= len_c;
               conv_start <= 1'b1;
               conv_chan  <= multi ? 2'h0 : chan_lim; // R06
            end
         end else if (conv_done) begin
            res_mem[sc_idx_q] <= {conv_chan, conv_data}; // R11
            if ({1'b0, sc_idx_q} + 4'd1 == sc_len_q) begin
               sc_busy_q  <= 1'b0;
               scan_end_q <= 1'b1;
               res_len_q  <= sc_len_q;
            end else begin
               sc_idx_q   <= sc_idx_q + 3'd1;
               conv_start <= 1'b1;
               conv_chan  <= multi ? sc_idx_q[1:0] + 2'h1 : chan_lim; // R02
            end
         end
      end
   end

endmodule // adc_config_scan_control
`default_nettype wire

// file: bench/adc_config_scan_control_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module adc_config_scan_control_monitor #(
   parameter MON_BYTES = 13,
   parameter RES_DEPTH = 8
) (
   input wire       ref_clk,
   input wire       rst,
   input wire       scl_in,
   input wire       sda_in,
   input wire       scl_oe,
   input wire       sda_oe,
   input wire       conv_start,
   input wire [1:0] conv_chan,
   input wire [1:0] conv_neg_chan,
   input wire       conv_diff,
   input wire       conv_bipolar,
   input wire [1:0] vref_sel,
   input wire       ext_clock_sel,
   input wire       hs_mode,
   input wire       powered,
   input wire       monitor_active,
   input wire       readback_en,
   input wire       int_clear
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence stop_s;
      $rose(sda_in) && scl_in && $past(scl_in);
   endsequence
   sequence scl_held_s;
      scl_in && $past(scl_in) && $past(scl_in, 2);
   endsequence
   pair_map_a: assert property (conv_neg_chan == (conv_chan ^ 2'h1))
      else $error("negative input not paired");
   se_unipolar_a: assert property (!conv_diff |-> !conv_bipolar)
      else $error("bipolar while single-ended");
   ref_excl_a: assert property (conv_start && monitor_active && vref_sel[0]
      |-> conv_chan != 2'h3) else $error("reference pin scanned");
   hs_exit_a: assert property (hs_mode ##0 stop_s |-> ##[1:6] !hs_mode)
      else $error("fast mode not restored");
   ext_idle_a: assert property (ext_clock_sel && !monitor_active ##0 stop_s
      |-> ##[1:8] !powered) else $error("no power down on stop");
   wake_a: assert property ($rose(powered) |-> ##[0:30] sda_oe)
      else $error("power up without address ack");
   cfg_clear_a: assert property ($rose(int_clear)
      |-> ##[0:2] !(conv_diff || monitor_active || readback_en))
      else $error("configuration not cleared");
   stretch_a: assert property ($rose(scl_oe) |-> ##[0:4] conv_start)
      else $error("stretch without conversion");
   sda_quiet_a: assert property (scl_held_s |-> $stable(sda_oe))
      else $error("data moved while clock high");
endmodule // adc_config_scan_control_monitor
`default_nettype wire

// file: bench/i2c_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model (
   input  wire  ref_clk,
   input  wire  scl,
   input  wire  sda,
   output logic scl_oe_m,
   output logic sda_oe_m
);
   initial begin
      scl_oe_m = 1'h0;
      sda_oe_m = 1'h0;
   end
   task automatic hold(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // wait for released clock high, wait out stretching
   task automatic sclhi;
      for (int t = 0; t < 9000 && !scl; t++) @(negedge ref_clk);
      hold(5);
   endtask
   task automatic bitx(input logic b, output logic r);
      sda_oe_m = !b;
      hold(3);
      scl_oe_m = 1'h0;
      sclhi;
      r = sda;
      scl_oe_m = 1'h1;
      hold(2);
   endtask
   task automatic xfer(input logic [7:0] d, input logic a,
                       output logic [7:0] q, output logic nine);
      for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
      bitx(a, nine);
   endtask
   task automatic start;
      sda_oe_m = 1'h0;
      hold(3);
      scl_oe_m = 1'h0;
      sclhi;
      sda_oe_m = 1'h1;
      hold(5);
      scl_oe_m = 1'h1;
      hold(3);
   endtask
   task automatic stop;
      sda_oe_m = 1'h1;
      hold(3);
      scl_oe_m = 1'h0;
      sclhi;
      sda_oe_m = 1'h0;
      hold(8);
   endtask
endmodule // i2c_master_model
`default_nettype wire

// file: bench/adc_config_scan_control_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin \
   num_checks++; \
   if ((s) !== (e)) begin \
      err_total++; \
      $display("mismatch %0s exp %h got %h", n, e, s); \
   end \
end
module adc_config_scan_control_test;
   logic        ref_clk = 1'h0;
   logic        rst = 1'h1;
   logic        a0_pin = 1'h0;
   logic        conv_done = 1'h0;
   logic [11:0] conv_data = 12'h000;
   wire         scl_oe_m, sda_oe_m, scl_oe, sda_oe, conv_start;
   wire         conv_diff, conv_bipolar, ref_power_on, ext_clock_sel;
   wire         hs_mode, powered, monitor_active, readback_en, int_clear;
   wire [1:0]   conv_chan, conv_neg_chan, vref_sel;
   wire         scl_in = !(scl_oe | scl_oe_m);
   wire         sda_in = !(sda_oe | sda_oe_m);
   wire [6:0]   adr = {6'h1A, a0_pin};
   logic [13:0] res_q[$];
   int          cd = 0, cyc = 0, err_total = 0, num_checks = 0;
   adc_config_scan_control uut (.ref_clk, .rst, .scl_in, .scl_out(), .scl_oe,
      .sda_in, .sda_out(), .sda_oe, .a0_pin, .conv_start, .conv_chan,
      .conv_neg_chan, .conv_diff, .conv_bipolar, .conv_done, .conv_data,
      .vref_sel, .ref_power_on, .ext_clock_sel, .hs_mode, .powered,
      .monitor_active, .readback_en, .int_clear);
   i2c_master_model m (.ref_clk, .scl(scl_in), .sda(sda_in), .scl_oe_m,
      .sda_oe_m);
   always #50 ref_clk = !ref_clk;
   // converter stand-in, result three cycles after start
   always @(negedge ref_clk) begin
      conv_done = 1'h0;
      if (conv_start) cd = 3;
      else if (cd > 0) begin
         cd = cd - 1;
         if (cd == 0) begin
            conv_data = 12'($urandom);
            conv_done = 1'h1;
            res_q.push_back({conv_chan, conv_data});
         end
      end
   end
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 60000) begin
         err_total++;
         complete_run;
      end
   end
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic tend(input string s);
      $display("test %0s done", s);
   endtask
   function automatic int nres(logic [7:0] c, logic s0);
      if (c[6:5] == 2'h1) return 8;
      if (c[6:5] == 2'h3) return 1;
      return (c[2:1] == 2'h3 && s0) ? 3 : c[2:1] + 1;
   endfunction
   function automatic logic [1:0] tagof(logic [7:0] c, int k);
      return (c[6:5] == 2'h0) ? 2'(k) : c[2:1];
   endfunction
   task automatic send(input logic [7:0] d);
      logic [7:0] q;
      logic       n;
      m.xfer(d, 1'h1, q, n);
      `CHK("ack", 1'h0, n)
   endtask
   task automatic recv(input logic nack, output logic [7:0] q);
      logic n;
      m.xfer(8'hFF, nack, q, n);
   endtask
   task automatic wr(input logic [7:0] a, b);
      m.start;
      send({adr, 1'h0});
      send(a);
      if (b !== 8'h00) send(b);
      m.stop;
   endtask
   task automatic scan_test(input logic [7:0] c, s);
      logic [7:0] q;
      int         n, k;
      n = nres(c, s[5]);
      wr(c, s);
      `CHK("diff", !c[0], conv_diff)
      `CHK("bipolar", s[2] & !c[0], conv_bipolar)
      `CHK("vref", s[6:5], vref_sel)
      res_q.delete();
      m.start;
      send({adr, 1'h1});
      for (k = 0; k < n; k++) begin
         recv(1'h0, q);
         `CHK("first", {1'h1, tagof(c, k), 1'h1, res_q[k][11:8]}, q)
         recv(k == n - 1, q);
         `CHK("second", res_q[k][7:0], q)
      end
      m.stop;
      `CHK("results", n, res_q.size())
      `CHK("idle", 1'h0, powered)
      tend("scan");
   endtask
   initial begin
      int         i;
      logic       n;
      logic [7:0] q;
      logic [9:0] rv;
      void'($urandom(32'he2b1));
      a0_pin = 1'($urandom);
      repeat (10) @(negedge ref_clk);
      rst = 1'h0;
      repeat (4) @(negedge ref_clk);
      rv = {vref_sel, ref_power_on, ext_clock_sel, conv_diff, conv_bipolar,
            monitor_active, readback_en, powered, hs_mode};
      `CHK("reset", 10'h000, rv)
      m.start;
      m.xfer({adr ^ 7'h01, 1'h0}, 1'h1, q, n);
      `CHK("foreign", 1'h1, n)
      m.xfer(8'h19, 1'h1, q, n);
      m.stop;
      `CHK("ignored", 1'h0, readback_en)
      tend("address");
      scan_test(8'h07, 8'hA2);
      for (i = 0; i < 6; i++)
         scan_test({1'h0, 2'((i % 3 == 2) ? 3 : i % 3), 2'h0, 3'($urandom)},
                   8'h82 | (8'($urandom) & 8'h24));
      wr(8'h47, 8'hA2);
      `CHK("monitor", 1'h1, monitor_active)
      repeat (60) @(negedge ref_clk);
      wr(8'h19, 8'h00);
      `CHK("readback", 1'h1, readback_en)
      wr(8'h5A, 8'hA0);
      rv = {7'h00, readback_en, monitor_active, conv_diff};
      `CHK("cleared", 10'h000, rv)
      `CHK("setup kept", 2'h1, vref_sel)
      wr(8'h01, 8'h00);
      tend("config");
      m.start;
      send({adr, 1'h0});
      send(8'h83);
      for (i = 0; i < 13; i++) send(8'h19);
      `CHK("extension", 1'h0, readback_en)
      send(8'h19);
      `CHK("after 13", 1'h1, readback_en)
      m.start;
      send({adr, 1'h1});
      recv(1'h0, q);
      `CHK("readback 0", 8'h19, q)
      recv(1'h1, q);
      `CHK("readback 1", 8'h19, q)
      m.start;
      send({adr, 1'h0});
      send(8'h83);
      send(8'h19);
      m.start;
      send({adr, 1'h0});
      send(8'h01);
      m.stop;
      `CHK("sr ends", 1'h0, readback_en)
      m.start;
      m.xfer(8'h08, 1'h1, q, n);
      `CHK("hs nack", 1'h1, n)
      `CHK("hs on", 1'h1, hs_mode)
      m.start;
      send({adr, 1'h0});
      `CHK("woken", 1'h1, powered)
      send(8'h8A);
      m.stop;
      `CHK("hs off", 1'h0, hs_mode)
      `CHK("ext idle", 1'h0, powered)
      wr(8'h82, 8'h00);
      tend("bus");
      complete_run;
   end
endmodule // adc_config_scan_control_test
bind adc_config_scan_control adc_config_scan_control_monitor #(
   .MON_BYTES(MON_BYTES), .RES_DEPTH(RES_DEPTH)) chk (.ref_clk, .rst,
   .scl_in, .sda_in, .scl_oe, .sda_oe, .conv_start, .conv_chan,
   .conv_neg_chan, .conv_diff, .conv_bipolar, .vref_sel, .ext_clock_sel,
   .hs_mode, .powered, .monitor_active, .readback_en, .int_clear);
`default_nettype wire
